// [hw/vcg_pkg.sv]
// constants, types and register map of the valve cycle phase generator
package vcg_pkg;
  // clock and timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int DEB_TIME_US = 200;  // input settle time
  localparam int DEB_CYC     = DEB_TIME_US * CLK_MHZ;
  localparam int MS_TIME_US  = 1000; // ramp time unit
  localparam int MS_CYC_DEF  = MS_TIME_US * CLK_MHZ;
  // dither rate, kept as half-period clock counts
  localparam int DITH_HZ_DEF = 195;
  localparam int DITH_HZ_MIN = 130;
  localparam int DITH_HZ_MAX = 488;
  localparam logic [15:0] DITH_HP_DEF = 16'(CLK_HZ / (2 * DITH_HZ_DEF));
  localparam logic [15:0] DITH_HP_MAX = 16'(CLK_HZ / (2 * DITH_HZ_MIN));
  localparam logic [15:0] DITH_HP_MIN = 16'(CLK_HZ / (2 * DITH_HZ_MAX));
  localparam logic [11:0] DITH_AMP_DEF = 12'h020;
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SCALE  = 8'h04;
  localparam logic [7:0] OFS_BIAS   = 8'h08;
  localparam logic [7:0] OFS_THR    = 8'h0C;
  localparam logic [7:0] OFS_DITH   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PHASE  = 8'h20;
  localparam int PHASE_CNT = 6;
  // control fields
  localparam int CTRL_SEQ  = 0;  // 1 = sequenced mode
  localparam int CTRL_NC   = 1;  // 6 bits, 1 = input active low
  localparam int CTRL_IMP  = 7;  // 4 bits, 1 = switch impulsive
  localparam int CTRL_AFWD = 11; // forward starts after backward
  localparam int CTRL_ABWD = 12; // backward starts after forward
  localparam int CTRL_FCNT = 13; // 2 bits, forward phase count
  localparam int CTRL_BCNT = 15; // 2 bits, backward phase count
  // status fields
  localparam int STS_PH  = 0;
  localparam int STS_FWD = 3;
  localparam int STS_BWD = 4;
  localparam int STS_IN  = 5;
  localparam int STS_ALM = 11;
  localparam int STS_FLT = 16;
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0001_4000;
  localparam logic [31:0] SCALE_RST = 32'h0FFF_0FFF;
  localparam logic [31:0] BIAS_RST  = 32'h0000_0000;
  localparam logic [31:0] THR_RST   = 32'h0000_0000;
  localparam logic [31:0] DITH_RST  = {4'h0, DITH_AMP_DEF, DITH_HP_DEF};
  localparam logic [31:0] PHASE_RST = 32'h0000_0000;
  // arithmetic and limits
  localparam logic [2:0] PH_NONE  = 3'h7;
  localparam logic [7:0] SPD_MAX  = 8'h64;  // 100 percent
  localparam logic [9:0] PCT_MUL  = 10'h28F; // 1/100 in 2^-16
  localparam logic [2:0] MAX_TOTAL = 3'h4;
  localparam logic [1:0] MAX_DIR   = 2'h3;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01, ST_CHECK = 6'h02, ST_READY = 6'h04,
    ST_FWD   = 6'h08, ST_BWD   = 6'h10, ST_JOG   = 6'h20
  } vcg_state_e;
  typedef struct packed {
    logic [15:0] ramp;  // ramp time in ms
    logic [6:0]  rsvd;
    logic        neg;   // sequenced mode: drive negative side
    logic [7:0]  speed; // percent
  } vcg_phase_s;
  typedef struct packed {
    logic gen;
    logic under;
    logic over;
    logic shrt;
    logic open;
  } vcg_alarm_s;
endpackage : vcg_pkg

// [hw/vcg_top.sv]
// valve cycle phase generator with apb register file
// Summary of operation
// - six inputs choose the active phase
// - input polarity configurable, high active default
// - fault output low while any fault
// - coil short, open or generator fault flagged
// - alarms for coil and temperature
// - separate positive and negative current scales
// - bias added above threshold, default zero
// - positive bias positive side, negative bias negative
// - dither rate 130 to 488 Hz, default 195
// - automatic cycle mode after reset
// - input change advances to next phase
// - fifth starts forward, sixth starts backward
// - first four inputs step cycle phases
// - four phases total, three per direction
// - each phase holds speed and ramp time
// - switches normally closed/open, impulsive/continuous
// - direction starts by input or automatically
// - phase, direction and inputs readable
// - sequenced mode picks one of six phases
// - sequenced mode inputs always level sensitive
// - enable low stops valve, resets generator
// - inputs checked before generator enabled
// - enable floating allows jogging by start inputs in automatic mode
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module vcg_top #(
  parameter int MS_CYC = vcg_pkg::MS_CYC_DEF // cycles per ms
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        ONOFF_IN_1,
  input  wire logic        ONOFF_IN_2,
  input  wire logic        ONOFF_IN_3,
  input  wire logic        ONOFF_IN_4,
  input  wire logic        START_FORWARD_IN,
  input  wire logic        START_BACKWARD_IN,
  input  wire logic        ENABLE_IN,
  input  wire logic        ENABLE_FLOAT,
  input  wire logic        COIL_OPEN,
  input  wire logic        COIL_SHORT,
  input  wire logic        OVER_TEMP,
  input  wire logic        UNDER_TEMP,
  output logic             FAULT_N,
  output logic      [15:0] CUR_CMD_A,
  output logic      [15:0] CUR_CMD_B
);
  // absolute difference of two signed levels
  function automatic logic [7:0] vcg_dist(logic signed [7:0] a,
                                          logic signed [7:0] b);
    logic signed [8:0] d;
    d = 9'(a) - 9'(b);
    return d[8] ? 8'(-d) : d[7:0];
  endfunction : vcg_dist

  logic [31:0] ctrl_reg;  // mode, polarity, start options
  logic [31:0] scale_reg; // positive low half, negative high
  logic [31:0] bias_reg;  // positive low half, negative high
  logic [31:0] thr_reg;   // bias threshold in percent
  logic [31:0] dith_reg;  // half period and amplitude
  vcg_pkg::vcg_phase_s phase_reg [vcg_pkg::PHASE_CNT];
  logic [5:0]  s1_reg, s2_reg;   // input synchroniser
  logic [5:0]  smp_reg, deb_reg; // debounce sample and result
  logic [11:0] dcnt_reg;         // debounce tick counter
  logic [5:0]  act, act_q_reg;   // active levels, previous
  logic        sw_ev;            // switch event, auto mode
  logic        fwd_go, bwd_go;   // start edges
  vcg_pkg::vcg_state_e st_reg;
  logic [2:0]  ph_reg, seq_ph;
  logic [1:0]  fcnt, bcnt;
  logic        gen_flt, seq_mode, en, drive;
  vcg_pkg::vcg_alarm_s alm_reg;
  logic signed [7:0] tgt, ref_reg, tgt_l_reg;
  logic [7:0]  d_l_reg;          // ramp distance
  logic [31:0] rl_reg, acc_reg;  // ramp length, accumulator
  logic [7:0]  mag;
  logic [15:0] hp, dith_cnt_reg;
  logic        dph_reg;          // dither polarity
  logic [33:0] prod;
  logic signed [18:0] sum;
  logic [15:0] cur_sat;
  logic        mapped, ph_hit;
  logic [31:0] rdata;

  assign seq_mode = ctrl_reg[vcg_pkg::CTRL_SEQ];
  assign fcnt     = ctrl_reg[vcg_pkg::CTRL_FCNT +: 2];
  assign bcnt     = ctrl_reg[vcg_pkg::CTRL_BCNT +: 2];
  assign en       = ENABLE_IN & ~ENABLE_FLOAT;
  // a bad phase split is a generator fault
  assign gen_flt  = ~seq_mode & (fcnt == 2'h0 | bcnt == 2'h0 |
                    3'(fcnt) + 3'(bcnt) > vcg_pkg::MAX_TOTAL);

  // two-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
    end else begin
      s1_reg <= {START_BACKWARD_IN, START_FORWARD_IN, ONOFF_IN_4,
                 ONOFF_IN_3, ONOFF_IN_2, ONOFF_IN_1};
      s2_reg <= s1_reg;
    end
  end

  // shared tick debounce: two equal samples in a row are accepted,
  // so a bouncing contact yields one clean transition
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      dcnt_reg <= 12'h000;
      smp_reg  <= 6'h00;
      deb_reg  <= 6'h00;
    end else if (dcnt_reg == 12'(vcg_pkg::DEB_CYC - 1)) begin
      dcnt_reg <= 12'h000;
      smp_reg  <= s2_reg;
      if (s2_reg == smp_reg) deb_reg <= s2_reg;
    end else begin
      dcnt_reg <= dcnt_reg + 12'h001;
    end
  end

  // polarity: a set bit makes the input active when low
  assign act = deb_reg ^ ctrl_reg[vcg_pkg::CTRL_NC +: 6];

  always_ff @(posedge REF_CLK) begin
    if (RESET) act_q_reg <= 6'h00;
    else       act_q_reg <= act;
  end

  // switch events and start edges
  always_comb begin
    sw_ev = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (ctrl_reg[vcg_pkg::CTRL_IMP + i])
        sw_ev = sw_ev | (act[i] & ~act_q_reg[i]);
      else
        sw_ev = sw_ev | (act[i] ^ act_q_reg[i]);
    end
    fwd_go = act[4] & ~act_q_reg[4];
    bwd_go = act[5] & ~act_q_reg[5];
  end

  // sequenced mode: lowest active input picks the phase, by level
  always_comb begin
    seq_ph = vcg_pkg::PH_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (act[i]) seq_ph = 3'(i);
    end
  end

  // phase sequencer
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_reg <= vcg_pkg::ST_IDLE;
      ph_reg <= vcg_pkg::PH_NONE;
    end else if (seq_mode) begin
      st_reg <= vcg_pkg::ST_IDLE;
      ph_reg <= en ? seq_ph : vcg_pkg::PH_NONE;
    end else if (ENABLE_FLOAT) begin
      st_reg <= vcg_pkg::ST_JOG;
      ph_reg <= vcg_pkg::PH_NONE;
    end else if (~en | gen_flt) begin
      st_reg <= vcg_pkg::ST_IDLE;
      ph_reg <= vcg_pkg::PH_NONE;
    end else begin
      unique case (st_reg)
        vcg_pkg::ST_IDLE, vcg_pkg::ST_JOG: begin
          st_reg <= vcg_pkg::ST_CHECK;
        end
        vcg_pkg::ST_CHECK: begin
          // starts must be released before the generator runs
          if (~act[4] & ~act[5]) st_reg <= vcg_pkg::ST_READY;
        end
        vcg_pkg::ST_READY: begin
          if (fwd_go) begin
            st_reg <= vcg_pkg::ST_FWD;
            ph_reg <= 3'h0;
          end else if (bwd_go) begin
            st_reg <= vcg_pkg::ST_BWD;
            ph_reg <= 3'(fcnt);
          end
        end
        vcg_pkg::ST_FWD: begin
          if (sw_ev) begin
            if (ph_reg == 3'(fcnt) - 3'h1) begin
              if (ctrl_reg[vcg_pkg::CTRL_ABWD]) begin
                st_reg <= vcg_pkg::ST_BWD;
                ph_reg <= 3'(fcnt);
              end else begin
                st_reg <= vcg_pkg::ST_READY;
                ph_reg <= vcg_pkg::PH_NONE;
              end
            end else begin
              ph_reg <= ph_reg + 3'h1;
            end
          end
        end
        vcg_pkg::ST_BWD: begin
          if (sw_ev) begin
            if (ph_reg == 3'(fcnt) + 3'(bcnt) - 3'h1) begin
              if (ctrl_reg[vcg_pkg::CTRL_AFWD]) begin
                st_reg <= vcg_pkg::ST_FWD;
                ph_reg <= 3'h0;
              end else begin
                st_reg <= vcg_pkg::ST_READY;
                ph_reg <= vcg_pkg::PH_NONE;
              end
            end else begin
              ph_reg <= ph_reg + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // signed target: forward positive, backward negative
  always_comb begin
    tgt = 8'sh00;
    if (st_reg == vcg_pkg::ST_JOG) begin
      // jog uses the first phase speed
      if (act[4] & ~act[5])
        tgt = 8'(phase_reg[0].speed);
      else if (act[5] & ~act[4])
        tgt = -8'(phase_reg[0].speed);
    end else if (ph_reg != vcg_pkg::PH_NONE) begin
      tgt = 8'(phase_reg[ph_reg].speed);
      if (seq_mode ? phase_reg[ph_reg].neg : st_reg == vcg_pkg::ST_BWD)
        tgt = -tgt;
    end
  end
  assign drive = en | ENABLE_FLOAT;

  // linear ramp: distance times clock against ramp length
  always_ff @(posedge REF_CLK) begin
    if (RESET | ~drive) begin
      ref_reg   <= 8'sh00;
      tgt_l_reg <= 8'sh00;
      d_l_reg   <= 8'h00;
      rl_reg    <= 32'h0000_0000;
      acc_reg   <= 32'h0000_0000;
    end else if (tgt != tgt_l_reg) begin
      tgt_l_reg <= tgt;
      d_l_reg   <= vcg_dist(tgt, ref_reg);
      // no phase (idle, jog, none selected) has no stored ramp: jump
      rl_reg    <= (ph_reg == vcg_pkg::PH_NONE) ? 32'h0000_0000
                   : 32'(phase_reg[ph_reg].ramp) * 32'(MS_CYC);
      acc_reg   <= 32'h0000_0000;
    end else if (ref_reg != tgt_l_reg) begin
      if (rl_reg == 32'h0000_0000) begin
        ref_reg <= tgt_l_reg;
      end else if (acc_reg + 32'(d_l_reg) >= rl_reg) begin
        acc_reg <= acc_reg + 32'(d_l_reg) - rl_reg;
        ref_reg <= ref_reg + (tgt_l_reg > ref_reg ? 8'sh01 : -8'sh01);
      end else begin
        acc_reg <= acc_reg + 32'(d_l_reg);
      end
    end
  end

  // dither square wave, period clamped to the legal rate band
  always_comb begin
    hp = dith_reg[15:0];
    if (hp < vcg_pkg::DITH_HP_MIN) hp = vcg_pkg::DITH_HP_MIN;
    if (hp > vcg_pkg::DITH_HP_MAX) hp = vcg_pkg::DITH_HP_MAX;
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      dith_cnt_reg <= 16'h0000;
      dph_reg      <= 1'b0;
    end else if (dith_cnt_reg >= hp - 16'h0001) begin
      dith_cnt_reg <= 16'h0000;
      dph_reg      <= ~dph_reg;
    end else begin
      dith_cnt_reg <= dith_cnt_reg + 16'h0001;
    end
  end

  // current command: scale, bias above threshold, dither
  always_comb begin
    mag  = vcg_dist(ref_reg, 8'sh00);
    prod = 34'(mag) * 34'(ref_reg[7] ? scale_reg[31:16]
           : scale_reg[15:0]) * 34'(vcg_pkg::PCT_MUL);
    sum  = 19'(prod[31:16]);
    if (mag > thr_reg[7:0])
      sum = sum + 19'(ref_reg[7] ? bias_reg[31:16]
            : bias_reg[15:0]);
    if (mag != 8'h00)
      sum = dph_reg ? sum + 19'(dith_reg[27:16])
            : sum - 19'(dith_reg[27:16]);
    if (sum < 19'sh0) cur_sat = 16'h0000;
    else if (sum > 19'sh0FFFF) cur_sat = 16'hFFFF;
    else cur_sat = sum[15:0];
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CUR_CMD_A <= 16'h0000;
      CUR_CMD_B <= 16'h0000;
    end else begin
      CUR_CMD_A <= (drive & ~ref_reg[7]) ? cur_sat : 16'h0000;
      CUR_CMD_B <= (drive & ref_reg[7]) ? cur_sat : 16'h0000;
    end
  end

  // alarms and fault pin
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      alm_reg <= '0;
      FAULT_N <= 1'b1;
    end else begin
      alm_reg <= {gen_flt, UNDER_TEMP, OVER_TEMP, COIL_SHORT,
                  COIL_OPEN};
      FAULT_N <= ~(gen_flt | UNDER_TEMP | OVER_TEMP | COIL_SHORT |
                   COIL_OPEN);
    end
  end

  // apb decode; zero wait states
  assign ph_hit = PADDR[7:5] == vcg_pkg::OFS_PHASE[7:5] &
                  PADDR[4:2] < 3'(vcg_pkg::PHASE_CNT) & PADDR[1:0] == 2'h0;
  assign mapped = ph_hit | PADDR == vcg_pkg::OFS_CTRL |
                  PADDR == vcg_pkg::OFS_SCALE | PADDR == vcg_pkg::OFS_BIAS |
                  PADDR == vcg_pkg::OFS_THR | PADDR == vcg_pkg::OFS_DITH |
                  PADDR == vcg_pkg::OFS_STATUS;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // register writes in the access phase
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_reg  <= vcg_pkg::CTRL_RST;
      scale_reg <= vcg_pkg::SCALE_RST;
      bias_reg  <= vcg_pkg::BIAS_RST;
      thr_reg   <= vcg_pkg::THR_RST;
      dith_reg  <= vcg_pkg::DITH_RST;
      for (int i = 0; i < vcg_pkg::PHASE_CNT; i++)
        phase_reg[i] <= vcg_pkg::PHASE_RST;
    end else if (PSEL & PENABLE & PWRITE) begin
      if (ph_hit) phase_reg[PADDR[4:2]] <= PWDATA;
      else if (PADDR == vcg_pkg::OFS_CTRL) ctrl_reg <= PWDATA;
      else if (PADDR == vcg_pkg::OFS_SCALE) scale_reg <= PWDATA;
      else if (PADDR == vcg_pkg::OFS_BIAS) bias_reg <= PWDATA;
      else if (PADDR == vcg_pkg::OFS_THR) thr_reg <= PWDATA;
      else if (PADDR == vcg_pkg::OFS_DITH) dith_reg <= PWDATA;
    end
  end

  // read mux; status shows phase, direction, debounced inputs, alarms
  always_comb begin
    rdata = 32'h0000_0000;
    if (ph_hit) rdata = phase_reg[PADDR[4:2]];
    else if (PADDR == vcg_pkg::OFS_CTRL) rdata = ctrl_reg;
    else if (PADDR == vcg_pkg::OFS_SCALE) rdata = scale_reg;
    else if (PADDR == vcg_pkg::OFS_BIAS) rdata = bias_reg;
    else if (PADDR == vcg_pkg::OFS_THR) rdata = thr_reg;
    else if (PADDR == vcg_pkg::OFS_DITH) rdata = dith_reg;
    else if (PADDR == vcg_pkg::OFS_STATUS) begin
      rdata[vcg_pkg::STS_PH +: 3]  = ph_reg;
      rdata[vcg_pkg::STS_FWD]      = st_reg == vcg_pkg::ST_FWD;
      rdata[vcg_pkg::STS_BWD]      = st_reg == vcg_pkg::ST_BWD;
      rdata[vcg_pkg::STS_IN +: 6]  = deb_reg;
      rdata[vcg_pkg::STS_ALM +: 5] = alm_reg;
      rdata[vcg_pkg::STS_FLT]      = ~FAULT_N;
    end
  end
  // read data captured in the setup cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) PRDATA <= 32'h0000_0000;
    else if (PSEL & ~PENABLE & ~PWRITE) PRDATA <= rdata;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  property p_fault_low;
    (COIL_OPEN | OVER_TEMP | UNDER_TEMP) |=> !FAULT_N;
  endproperty
  a_fault_low: assert property (p_fault_low)
    else $error("fault pin not low on fault");
  property p_short_flt;
    COIL_SHORT | gen_flt |=> !FAULT_N && alm_reg != '0;
  endproperty
  a_short_flt: assert property (p_short_flt)
    else $error("short or generator fault not flagged");
  property p_temp_alm;
    OVER_TEMP && !UNDER_TEMP |=> alm_reg.over && !alm_reg.under;
  endproperty
  a_temp_alm: assert property (p_temp_alm)
    else $error("temperature alarm wrong");
  property p_advance;
    st_reg == vcg_pkg::ST_FWD && sw_ev && en && !ENABLE_FLOAT &&
    !seq_mode && !gen_flt && ph_reg < 3'(fcnt) - 3'h1
    |=> ph_reg == $past(ph_reg) + 3'h1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("phase did not advance");
  property p_start_fwd;
    st_reg == vcg_pkg::ST_READY && fwd_go && en && !ENABLE_FLOAT &&
    !seq_mode && !gen_flt |=> st_reg == vcg_pkg::ST_FWD && ph_reg == 3'h0;
  endproperty
  a_start_fwd: assert property (p_start_fwd)
    else $error("forward start missed");
  property p_disable;
    !en && !ENABLE_FLOAT |=> ph_reg == vcg_pkg::PH_NONE ##1
      CUR_CMD_A == 16'h0000 && CUR_CMD_B == 16'h0000;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable did not stop valve");
  property p_check;
    st_reg == vcg_pkg::ST_CHECK && (act[4] | act[5]) |=>
      st_reg != vcg_pkg::ST_READY;
  endproperty
  a_check: assert property (p_check)
    else $error("generator enabled with start active");
  property p_seq_sel;
    seq_mode && en && act[0] |=> ph_reg == 3'h0;
  endproperty
  a_seq_sel: assert property (p_seq_sel)
    else $error("sequenced phase wrong");
  property p_ramp_step;
    drive && rl_reg != 32'h0 && tgt == tgt_l_reg |=>
      vcg_dist(ref_reg, $past(ref_reg)) <= 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp jumped more than one step");
  property p_dith_band;
    $changed(dph_reg) |-> dith_cnt_reg == 16'h0000 &&
      $past(dith_cnt_reg) >= vcg_pkg::DITH_HP_MIN - 16'h0001 &&
      $past(dith_cnt_reg) <= vcg_pkg::DITH_HP_MAX - 16'h0001;
  endproperty
  a_dith_band: assert property (p_dith_band)
    else $error("dither period out of band");
endmodule : vcg_top
`default_nettype wire

// [hw/vcg_unused_placeholder_never.sv]
// empty design unit holder
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [testbench/vcg_mcu.sv]
// machine controller and proximity switch model for the six inputs
`timescale 1ns/1ns
`default_nettype none
module vcg_mcu (
  input  wire logic       clk,   // reference clock
  input  wire logic [5:0] want,  // levels the bench asks for
  output logic      [5:0] lines  // electrical levels at the pins
);
  // contacts move just after an edge, never mid-cycle, so no race
  always_ff @(posedge clk) begin
    lines <= want;
  end
endmodule : vcg_mcu
`default_nettype wire

// [testbench/vcg_top_tb_top.sv]
// self-checking bench for the valve cycle phase generator
`timescale 1ns/1ns
`default_nettype none
module vcg_top_tb_top;
  logic        clk = 1'b0;       // 10 MHz reference
  logic        rst = 1'b1;       // synchronous reset
  logic        psel = 1'b0;      // apb select
  logic        pen = 1'b0;       // apb enable
  logic        pwr = 1'b0;       // apb direction
  logic [7:0]  padr = 8'h00;     // apb address
  logic [31:0] pwd = 32'h0;      // apb write data
  logic [31:0] prd;              // apb read data
  logic        prdy;             // apb ready
  logic        perr;             // apb error
  logic        flt_n;            // fault output
  logic        en = 1'b0;        // enable level
  logic        fl = 1'b0;        // enable pin floating
  logic [3:0]  alm = 4'h0;       // open, short, over, under
  logic [5:0]  want = 6'h00;     // requested input levels
  logic [5:0]  ln;               // input levels from the partner
  logic [15:0] cur_a;            // positive side command
  logic [15:0] cur_b;            // negative side command
  logic [15:0] lfsr = 16'h1864;  // fixed seed
  int          fail_count = 0;   // mismatches
  int          n_checks = 0;     // comparisons
  logic [31:0] q;                // last read data
  logic        e;                // last error flag
  logic [7:0]  ra [6] = '{vcg_pkg::OFS_CTRL, vcg_pkg::OFS_SCALE,
    vcg_pkg::OFS_BIAS, vcg_pkg::OFS_THR, vcg_pkg::OFS_DITH,
    vcg_pkg::OFS_STATUS};
  logic [31:0] rv [6] = '{vcg_pkg::CTRL_RST, vcg_pkg::SCALE_RST,
    vcg_pkg::BIAS_RST, vcg_pkg::THR_RST, vcg_pkg::DITH_RST, 32'h7};
  // clock
  always #50 clk = ~clk;
  // short ramp unit keeps the run brief
  vcg_top #(.MS_CYC(10)) dut (
    .REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .ONOFF_IN_1(ln[0]),
    .ONOFF_IN_2(ln[1]), .ONOFF_IN_3(ln[2]), .ONOFF_IN_4(ln[3]),
    .START_FORWARD_IN(ln[4]), .START_BACKWARD_IN(ln[5]),
    .ENABLE_IN(en), .ENABLE_FLOAT(fl), .COIL_OPEN(alm[0]),
    .COIL_SHORT(alm[1]), .OVER_TEMP(alm[2]), .UNDER_TEMP(alm[3]),
    .FAULT_N(flt_n), .CUR_CMD_A(cur_a), .CUR_CMD_B(cur_b));
  vcg_mcu mcu (.clk(clk), .want(want), .lines(ln));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 16) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wcyc
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next
  // current model: full scale, bias 0x10 only above threshold
  function automatic logic [31:0] cur_m(input int spd, input int thr);
    int c;
    c = (spd * 4095 * 655) >>> 16;
    if (spd > thr) c = c + 16;
    return 32'(c);
  endfunction : cur_m
  // sequenced mode: lowest active input wins, none gives 7
  function automatic logic [31:0] ph_m(input logic [5:0] act);
    for (int k = 0; k < 6; k++) if (act[k]) return 32'(k);
    return 32'h7;
  endfunction : ph_m
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[k]) begin
      apb(1'b0, ra[k], 32'h0);
      chk(q, rv[k]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(e), 32'h1);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      alm <= 4'(1 << k);
      wcyc(4);
      chk(32'(flt_n), 32'h0);
      apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
      chk(32'(q[16:11]), 32'h20 | 32'(1 << k));
      alm <= 4'h0;
      wcyc(4);
      chk(32'(flt_n), 32'h1);
    end
    $display("test alarms done");
    // dither amplitude zero so the command is exact
    apb(1'b1, vcg_pkg::OFS_DITH, {16'h0, vcg_pkg::DITH_HP_DEF});
    apb(1'b1, vcg_pkg::OFS_BIAS, 32'h0010_0010);
    apb(1'b1, vcg_pkg::OFS_THR, 32'h3C);
    apb(1'b1, vcg_pkg::OFS_PHASE, 32'h64);
    apb(1'b1, vcg_pkg::OFS_PHASE + 8'h04, 32'h0001_0032);
    en <= 1'b1;
    wcyc(10);
    want <= 6'h10;
    wcyc(4100);
    apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[10:0]), 32'h208);
    chk(32'(cur_a), cur_m(100, 60));
    chk(32'(cur_b), 32'h0);
    want <= 6'h11;
    wcyc(4100);
    apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[10:0]), 32'h229);
    chk(32'(cur_a), cur_m(50, 60));
    $display("test automatic cycle done");
    // floating enable: jog forward at the first phase speed
    fl <= 1'b1;
    wcyc(10);
    apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[10:0]), 32'h227);
    chk(32'(cur_a), cur_m(100, 60));
    fl <= 1'b0;
    // five phases in all is an illegal split
    apb(1'b1, vcg_pkg::OFS_CTRL, 32'h0001_6000);
    wcyc(2);
    chk(32'(flt_n), 32'h0);
    $display("test jog and phase split done");
    // first switch impulsive, backward follows forward by itself
    apb(1'b1, vcg_pkg::OFS_CTRL, vcg_pkg::CTRL_RST | 32'h1080);
    want <= 6'h00;
    wcyc(4100);
    want <= 6'h10;
    wcyc(4100);
    want <= 6'h11;
    wcyc(4100);
    want <= 6'h10;
    wcyc(4100);
    apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[4:0]), 32'h09);
    want <= 6'h11;
    wcyc(4100);
    apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[4:0]), 32'h12);
    $display("test impulsive switch done");
    want <= 6'h00;
    apb(1'b1, vcg_pkg::OFS_CTRL, vcg_pkg::CTRL_RST | 32'h41);
    // phase zero drives the negative side in sequenced mode
    apb(1'b1, vcg_pkg::OFS_PHASE, 32'h164);
    for (int k = 0; k < 5; k++) begin
      lfsr = lfsr_next(lfsr);
      want <= lfsr[5:0];
      wcyc(4100);
      apb(1'b0, vcg_pkg::OFS_STATUS, 32'h0);
      chk(32'(q[2:0]), ph_m(lfsr[5:0] ^ 6'h20));
      chk(32'(cur_b), (ph_m(lfsr[5:0] ^ 6'h20) == 32'h0) ?
          cur_m(100, 60) : 32'h0);
    end
    $display("test sequenced mode done");
    tally_and_finish();
  end
endmodule : vcg_top_tb_top
`default_nettype wire
